// ### core/dccu_pkg.sv
// Constants, types and reset state of the dual capture/compare unit
// Behaviour
// [RL1] Two units of sixteen channels give thirty-two capture/compare channels.
// [RL2] Each unit has two 16-bit timers with reload registers as time base.
// [RL3] Timer clock is a prescaled system clock or auxiliary timer overflow.
// [RL4] First timer of each unit may also count external count input edges.
// [RL5] Each channel picks either unit timer and capture or compare operation.
// [RL6] One pin per channel; channels 24 to 27 never drive an output.
// [RL7] Capture copies the assigned timer count into the channel on an edge.
// [RL8] Every capture raises that channel's own interrupt request.
// [RL9] Capture edge selectable: rising only, falling only, or both.
// [RL10] Compare channels match against their timer each cycle; mode decides. The code matches only in the cycle after a timer tick.
// [RL11] Mode 0: interrupt only, pin unchanged, many matches per period.
// [RL12] Mode 1: pin toggles on every match, many per period.
// [RL13] Mode 2: interrupt only, at most one per timer period.
// [RL14] Mode 3: pin high on match, low on timer overflow, once per period.
// [RL15] Double mode: two channels share one pin, toggling on either match.
// [RL16] Three-bit input select picks prescale 8,16,...,1024 for codes 0 to 7.
// [RL17] Timer reloads on overflow; reload zero gives full 16-bit period.
// [RL18] Finest resolution is one count per eight system clocks.
// [RL19] Each channel and timer has its own request flag and enable flag.
// [RL20] Timer counts one per tick and flags overflow when it wraps.
package dccu_pkg;
    localparam int         NCH          = 32;
    localparam int         NTMR         = 4;
    localparam int         CLK_PERIOD_NS = 20;
    localparam int         MIN_DIV      = 8;
    localparam int         MIN_RES_NS   = MIN_DIV * CLK_PERIOD_NS;
    localparam logic [1:0] SRC_PSC      = 2'h0;
    localparam logic [1:0] SRC_AUX      = 2'h1;
    localparam logic [1:0] SRC_EXT      = 2'h2;
    localparam logic [3:0] MD_OFF       = 4'h0;
    localparam logic [3:0] MD_CAP_RISE  = 4'h1;
    localparam logic [3:0] MD_CAP_FALL  = 4'h2;
    localparam logic [3:0] MD_CAP_BOTH  = 4'h3;
    localparam logic [3:0] MD_CMP0      = 4'h4;
    localparam logic [3:0] MD_CMP1      = 4'h5;
    localparam logic [3:0] MD_CMP2      = 4'h6;
    localparam logic [3:0] MD_CMP3      = 4'h7;
    localparam logic [3:0] MD_DBL       = 4'h8;
    localparam logic [11:0] OFS_TMR_CNT = 12'h000;
    localparam logic [11:0] OFS_TMR_RLD = 12'h010;
    localparam logic [11:0] OFS_TMR_CTL = 12'h020;
    localparam logic [11:0] OFS_CH_IF   = 12'h030;
    localparam logic [11:0] OFS_CH_IE   = 12'h034;
    localparam logic [11:0] OFS_TM_IF   = 12'h038;
    localparam logic [11:0] OFS_TM_IE   = 12'h03C;
    localparam logic [11:0] OFS_CH_VAL  = 12'h040;
    localparam logic [11:0] OFS_CH_MODE = 12'h0C0;
    localparam logic [11:0] OFS_END     = 12'h140;
    localparam logic [1:0]  RESP_OKAY   = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;

    typedef enum logic [3:0] {
        R_CNT, R_RLD, R_CTL, R_CHIF, R_CHIE, R_TMIF, R_TMIE, R_VAL, R_MODE,
        R_NONE
    } dccu_reg_t;

    typedef struct packed {
        logic        awvalid;
        logic [11:0] awaddr;
        logic        wvalid;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        bready;
        logic        arvalid;
        logic [11:0] araddr;
        logic        rready;
    } dccu_axi_req_t;

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } dccu_axi_rsp_t;

    // Timer control word: [2:0] prescale select, [4:3] source, [5] run
    typedef struct packed {
        logic [3:0][15:0] cnt;
        logic [3:0][15:0] rld;
        logic [3:0][5:0]  ctl;
        logic [3:0]       chg;
        logic [3:0]       ovf;
        logic [3:0]       tm_if;
        logic [3:0]       tm_ie;
        logic [3:0]       tm_irq;
        logic [31:0][15:0] val;
        logic [31:0][4:0] mode;
        logic [31:0]      done;
        logic [31:0]      pin;
        logic [31:0]      oe_b;
        logic [31:0]      pin_prev;
        logic [31:0]      ch_if;
        logic [31:0]      ch_ie;
        logic [31:0]      ch_irq;
        logic [1:0]       ext_prev;
        logic [9:0]       psc;
        logic             aw_rdy;
        logic             w_rdy;
        logic             ar_rdy;
        logic             bvalid;
        logic             rvalid;
        logic [11:0]      waddr;
        logic [31:0]      wdata;
        logic [3:0]       wstrb;
        logic [1:0]       bresp;
        logic [1:0]       rresp;
        logic [31:0]      rdata;
    } dccu_state_t;

    localparam dccu_state_t ST_RST = '{aw_rdy: 1'b1, w_rdy: 1'b1,
        ar_rdy: 1'b1, oe_b: 32'hFFFF_FFFF, default: '0};
endpackage : dccu_pkg

// ### core/dccu_top.sv
// Dual capture/compare unit with AXI4-Lite register access
//
// Design decisions made here: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ns
module dccu_top (
    input  wire logic                    clk,
    input  wire logic                    rst_b,
    input  wire dccu_pkg::dccu_axi_req_t axi_req,
    output dccu_pkg::dccu_axi_rsp_t      axi_rsp,
    input  wire logic [31:0]             cc_in,
    output logic [31:0]                  cc_out,
    output logic [31:0]                  cc_out_en_b,
    input  wire logic                    aux_ovf,
    input  wire logic [1:0]              ext_cnt,
    output logic [31:0]                  cc_irq,
    output logic [3:0]                   tmr_irq
);
    logic [1:0]            rst_sync;
    logic                  rst_n;
    dccu_pkg::dccu_state_t st_reg;
    dccu_pkg::dccu_state_t st_next;
    logic [3:0]            tick;
    logic [31:0]           match;
    logic [31:0]           chset;
    logic [3:0]            tmset;
    logic [31:0]           chclr;
    logic [3:0]            tmclr;
    logic                  wr_fire;
    logic [31:0]           wmask;
    logic [31:0]           wv;
    logic [11:0]           wa;
    logic [1:0]            tm;
    logic [3:0]            md;
    logic                  pmatch;

    function automatic logic psc_tick(input logic [9:0] p,
                                      input logic [2:0] sel);
        logic [10:0] m;
        m = (11'h008 << sel) - 11'h001;
        return ({1'b0, p} & m) == m;
    endfunction : psc_tick

    function automatic dccu_pkg::dccu_reg_t dec(input logic [11:0] a);
        dccu_pkg::dccu_reg_t r;
        r = dccu_pkg::R_NONE;
        if (a < dccu_pkg::OFS_TMR_RLD) r = dccu_pkg::R_CNT;
        else if (a < dccu_pkg::OFS_TMR_CTL) r = dccu_pkg::R_RLD;
        else if (a < dccu_pkg::OFS_CH_IF) r = dccu_pkg::R_CTL;
        else if (a == dccu_pkg::OFS_CH_IF) r = dccu_pkg::R_CHIF;
        else if (a == dccu_pkg::OFS_CH_IE) r = dccu_pkg::R_CHIE;
        else if (a == dccu_pkg::OFS_TM_IF) r = dccu_pkg::R_TMIF;
        else if (a == dccu_pkg::OFS_TM_IE) r = dccu_pkg::R_TMIE;
        else if (a < dccu_pkg::OFS_CH_MODE) r = dccu_pkg::R_VAL;
        else if (a < dccu_pkg::OFS_END) r = dccu_pkg::R_MODE;
        return r;
    endfunction : dec

    // Channel index inside the value or mode block
    function automatic logic [4:0] chx(input logic [11:0] a,
                                       input logic [11:0] base);
        logic [11:0] d;
        d = a - base;
        return d[6:2];
    endfunction : chx

    function automatic logic [31:0] rd_word(
        input dccu_pkg::dccu_state_t s, input logic [11:0] a);
        logic [31:0] r;
        r = 32'h0000_0000;
        unique case (dec(a))
            dccu_pkg::R_CNT:  r = {16'h0000, s.cnt[a[3:2]]};
            dccu_pkg::R_RLD:  r = {16'h0000, s.rld[a[3:2]]};
            dccu_pkg::R_CTL:  r = {26'h0, s.ctl[a[3:2]]};
            dccu_pkg::R_CHIF: r = s.ch_if;
            dccu_pkg::R_CHIE: r = s.ch_ie;
            dccu_pkg::R_TMIF: r = {28'h0, s.tm_if};
            dccu_pkg::R_TMIE: r = {28'h0, s.tm_ie};
            dccu_pkg::R_VAL:
                r = {16'h0000, s.val[chx(a, dccu_pkg::OFS_CH_VAL)]};
            dccu_pkg::R_MODE:
                r = {27'h0, s.mode[chx(a, dccu_pkg::OFS_CH_MODE)]};
            dccu_pkg::R_NONE: r = 32'h0000_0000;
        endcase
        return r;
    endfunction : rd_word

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rst_sync <= 2'h0;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_n = rst_sync[1];

    always_comb begin
        st_next = st_reg;
        tick    = 4'h0;
        match   = 32'h0;
        chset   = 32'h0;
        tmset   = 4'h0;
        chclr   = 32'h0;
        tmclr   = 4'h0;
        tm      = 2'h0;
        md      = 4'h0;
        pmatch  = 1'b0;
        wa      = {st_reg.waddr[11:2], 2'h0};
        wmask   = {{8{st_reg.wstrb[3]}}, {8{st_reg.wstrb[2]}},
                   {8{st_reg.wstrb[1]}}, {8{st_reg.wstrb[0]}}};
        wv      = (rd_word(st_reg, wa) & ~wmask) | (st_reg.wdata & wmask);
        wr_fire = !st_reg.aw_rdy && !st_reg.w_rdy && !st_reg.bvalid;
        st_next.psc      = st_reg.psc + 10'h001;
        st_next.ext_prev = ext_cnt;
        st_next.pin_prev = cc_in;

        // Time bases
        for (int t = 0; t < dccu_pkg::NTMR; t++) begin
            unique case (st_reg.ctl[t][4:3])
                dccu_pkg::SRC_PSC:
                    tick[t] = psc_tick(st_reg.psc, st_reg.ctl[t][2:0]); // [RL3] [RL16] [RL18]
                dccu_pkg::SRC_AUX: tick[t] = aux_ovf; // [RL3]
                dccu_pkg::SRC_EXT:
                    tick[t] = (t % 2 == 0) && ext_cnt[t / 2]
                              && !st_reg.ext_prev[t / 2]; // [RL4]
                default: tick[t] = 1'b0;
            endcase
            tick[t] = tick[t] && st_reg.ctl[t][5];
            st_next.chg[t] = tick[t];
            st_next.ovf[t] = 1'b0;
            if (tick[t]) begin
                if (st_reg.cnt[t] == 16'hFFFF) begin
                    st_next.cnt[t] = st_reg.rld[t]; // [RL17]
                    st_next.ovf[t] = 1'b1;
                    tmset[t]       = 1'b1; // [RL20]
                end else begin
                    st_next.cnt[t] = st_reg.cnt[t] + 16'h0001; // [RL20] [RL2]
                end
            end
        end

        // Compare is evaluated in the cycle after each timer tick, not after a count load
        for (int c = 0; c < dccu_pkg::NCH; c++) begin
            tm = {c[4], st_reg.mode[c][4]}; // [RL5]
            match[c] = st_reg.chg[tm] && st_reg.cnt[tm] == st_reg.val[c]; // [RL10]
        end

        for (int c = 0; c < dccu_pkg::NCH; c++) begin
            tm = {c[4], st_reg.mode[c][4]};
            md = st_reg.mode[c][3:0];
            pmatch = 1'b0;
            if (c % 16 < 8) begin
                pmatch = st_reg.chg[tm]
                         && st_reg.cnt[tm] == st_reg.val[c + 8];
            end
            if (st_reg.ovf[tm]) begin
                st_next.done[c] = 1'b0;
            end
            unique case (md)
                dccu_pkg::MD_CAP_RISE, dccu_pkg::MD_CAP_FALL,
                dccu_pkg::MD_CAP_BOTH: begin
                    if ((md != dccu_pkg::MD_CAP_FALL && cc_in[c]
                         && !st_reg.pin_prev[c])
                        || (md != dccu_pkg::MD_CAP_RISE && !cc_in[c]
                         && st_reg.pin_prev[c])) begin // [RL9]
                        st_next.val[c] = st_reg.cnt[tm]; // [RL7]
                        chset[c] = 1'b1; // [RL8]
                    end
                end
                dccu_pkg::MD_CMP0: chset[c] = match[c]; // [RL11]
                dccu_pkg::MD_CMP1: begin
                    if (match[c]) begin
                        st_next.pin[c] = !st_reg.pin[c]; // [RL12]
                        chset[c] = 1'b1;
                    end
                end
                dccu_pkg::MD_CMP2: begin
                    if (match[c] && !st_reg.done[c]) begin // [RL13]
                        st_next.done[c] = 1'b1;
                        chset[c] = 1'b1;
                    end
                end
                dccu_pkg::MD_CMP3: begin
                    if (st_reg.ovf[tm]) begin
                        st_next.pin[c] = 1'b0; // [RL14]
                    end
                    if (match[c] && !st_reg.done[c]) begin
                        st_next.pin[c]  = 1'b1; // [RL14]
                        st_next.done[c] = 1'b1;
                        chset[c] = 1'b1;
                    end
                end
                dccu_pkg::MD_DBL: begin
                    if (c % 16 < 8 && (match[c] || pmatch)) begin
                        st_next.pin[c] = !st_reg.pin[c]; // [RL15]
                        chset[c] = 1'b1;
                    end
                end
                dccu_pkg::MD_OFF: ;
                default: ;
            endcase
            st_next.oe_b[c] = !(md == dccu_pkg::MD_CMP1
                || md == dccu_pkg::MD_CMP3
                || (md == dccu_pkg::MD_DBL && c % 16 < 8))
                || (c >= 24 && c <= 27); // [RL6] [RL1]
        end

        // Bus write
        if (axi_req.awvalid && st_reg.aw_rdy) begin
            st_next.aw_rdy = 1'b0;
            st_next.waddr  = axi_req.awaddr;
        end
        if (axi_req.wvalid && st_reg.w_rdy) begin
            st_next.w_rdy = 1'b0;
            st_next.wdata = axi_req.wdata;
            st_next.wstrb = axi_req.wstrb;
        end
        if (wr_fire) begin
            st_next.bvalid = 1'b1;
            st_next.bresp  = dccu_pkg::RESP_OKAY;
            unique case (dec(wa))
                dccu_pkg::R_CNT: begin
                    // A loaded count must not look like a fresh tick
                    st_next.cnt[wa[3:2]] = wv[15:0];
                    st_next.chg[wa[3:2]] = 1'b0;
                end
                dccu_pkg::R_RLD:  st_next.rld[wa[3:2]] = wv[15:0];
                dccu_pkg::R_CTL:  st_next.ctl[wa[3:2]] = wv[5:0];
                dccu_pkg::R_CHIF: chclr = st_reg.wdata & wmask;
                dccu_pkg::R_CHIE: st_next.ch_ie = wv; // [RL19]
                dccu_pkg::R_TMIF: tmclr = st_reg.wdata[3:0] & wmask[3:0];
                dccu_pkg::R_TMIE: st_next.tm_ie = wv[3:0];
                dccu_pkg::R_VAL:
                    st_next.val[chx(wa, dccu_pkg::OFS_CH_VAL)] = wv[15:0];
                dccu_pkg::R_MODE:
                    st_next.mode[chx(wa, dccu_pkg::OFS_CH_MODE)] = wv[4:0];
                dccu_pkg::R_NONE: st_next.bresp = dccu_pkg::RESP_SLVERR;
            endcase
        end
        if (st_reg.bvalid && axi_req.bready) begin
            st_next.bvalid = 1'b0;
            st_next.aw_rdy = 1'b1;
            st_next.w_rdy  = 1'b1;
        end

        // Bus read
        if (axi_req.arvalid && st_reg.ar_rdy) begin
            st_next.ar_rdy = 1'b0;
            st_next.rvalid = 1'b1;
            st_next.rdata  = rd_word(st_reg, {axi_req.araddr[11:2], 2'h0});
            st_next.rresp  = dec({axi_req.araddr[11:2], 2'h0})
                == dccu_pkg::R_NONE ? dccu_pkg::RESP_SLVERR
                                    : dccu_pkg::RESP_OKAY;
        end
        if (st_reg.rvalid && axi_req.rready) begin
            st_next.rvalid = 1'b0;
            st_next.ar_rdy = 1'b1;
        end

        // A hardware set wins over a software clear
        st_next.ch_if  = (st_reg.ch_if & ~chclr) | chset; // [RL19] [RL8]
        st_next.tm_if  = (st_reg.tm_if & ~tmclr) | tmset; // [RL19] [RL20]
        st_next.ch_irq = st_next.ch_if & st_next.ch_ie; // [RL19]
        st_next.tm_irq = st_next.tm_if & st_next.tm_ie; // [RL19]
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_reg <= dccu_pkg::ST_RST;
        end else begin
            st_reg <= st_next;
        end
    end

    assign axi_rsp.awready = st_reg.aw_rdy;
    assign axi_rsp.wready  = st_reg.w_rdy;
    assign axi_rsp.bvalid  = st_reg.bvalid;
    assign axi_rsp.bresp   = st_reg.bresp;
    assign axi_rsp.arready = st_reg.ar_rdy;
    assign axi_rsp.rvalid  = st_reg.rvalid;
    assign axi_rsp.rdata   = st_reg.rdata;
    assign axi_rsp.rresp   = st_reg.rresp;
    assign cc_out      = st_reg.pin;
    assign cc_out_en_b = st_reg.oe_b;
    assign cc_irq      = st_reg.ch_irq;
    assign tmr_irq     = st_reg.tm_irq;

    // Checks on sample channels and timers
    logic [1:0] tm0;
    logic [3:0] md0;
    assign tm0 = {1'b0, st_reg.mode[0][4]};
    assign md0 = st_reg.mode[0][3:0];

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_capture_value: assert property ( // [RL7]
        md0 == dccu_pkg::MD_CAP_RISE && cc_in[0] && !st_reg.pin_prev[0]
        && !wr_fire |=> st_reg.val[0] == $past(st_reg.cnt[tm0]))
        else $error("capture did not latch timer");
    a_capture_irq: assert property ( // [RL8]
        md0 == dccu_pkg::MD_CAP_FALL && !cc_in[0] && st_reg.pin_prev[0]
        |=> st_reg.ch_if[0])
        else $error("capture raised no request");
    a_timer_reload: assert property ( // [RL17]
        tick[1] && st_reg.cnt[1] == 16'hFFFF && !wr_fire
        |=> st_reg.cnt[1] == $past(st_reg.rld[1]) && st_reg.ovf[1]
            ##1 st_reg.tm_if[1])
        else $error("timer wrap did not reload");
    a_timer_step: assert property ( // [RL20]
        tick[0] && st_reg.cnt[0] != 16'hFFFF && !wr_fire
        |=> st_reg.cnt[0] == $past(st_reg.cnt[0]) + 16'h0001)
        else $error("timer did not step by one");
    a_prescale_gap: assert property ( // [RL18]
        tick[0] && st_reg.ctl[0][4:3] == dccu_pkg::SRC_PSC
        && st_reg.ctl[0][2:0] == 3'h0 |=> !tick[0] [*7])
        else $error("prescaled ticks closer than eight clocks");
    a_toggle_pin: assert property ( // [RL12]
        st_reg.mode[6][3:0] == dccu_pkg::MD_CMP1 && match[6]
        |=> cc_out[6] != $past(cc_out[6]))
        else $error("mode 1 match did not toggle pin");
    a_mode3_clear: assert property ( // [RL14]
        st_reg.mode[8][3:0] == dccu_pkg::MD_CMP3
        && st_reg.ovf[{1'b0, st_reg.mode[8][4]}] && !match[8]
        |=> !cc_out[8])
        else $error("mode 3 overflow did not clear pin");
    a_mode2_once: assert property ( // [RL13]
        st_reg.mode[7][3:0] == dccu_pkg::MD_CMP2 && st_reg.done[7]
        && !st_reg.ovf[{1'b0, st_reg.mode[7][4]}] |-> !chset[7])
        else $error("mode 2 raised a second request");
    a_no_output: assert property ( // [RL6]
        cc_out_en_b[27:24] == 4'hF)
        else $error("channel 24 to 27 enabled an output");
    a_irq_gate: assert property ( // [RL19]
        cc_irq == (st_reg.ch_if & st_reg.ch_ie)
        && tmr_irq == (st_reg.tm_if & st_reg.tm_ie))
        else $error("request not gated by enable");

    c_capture: cover property (
        md0 == dccu_pkg::MD_CAP_BOTH && chset[0]);
    c_toggle: cover property (
        st_reg.mode[6][3:0] == dccu_pkg::MD_CMP1 && match[6]);
    c_wrap: cover property (tick[1] && st_reg.cnt[1] == 16'hFFFF);
    c_write: cover property (wr_fire ##1 axi_rsp.bvalid);
endmodule : dccu_top

// ### verification/dccu_pins_model.sv
// Far-side model: channel pins, auxiliary timer overflow, count inputs
`timescale 1ns/1ns
module dccu_pins_model (
    input  wire logic   clk,
    output logic [31:0] cc_in,
    output logic        aux_ovf,
    output logic [1:0]  ext_cnt
);
    initial begin
        cc_in   = 32'h0;
        aux_ovf = 1'b0;
        ext_cnt = 2'h0;
    end
    // Overflow events arrive as single-cycle pulses, spaced apart
    task automatic aux_pulse(input int n);
        repeat (n) begin
            @(posedge clk);
            aux_ovf <= 1'b1;
            @(posedge clk);
            aux_ovf <= 1'b0;
            repeat (4) @(posedge clk);
        end
    endtask : aux_pulse
    task automatic ext_edges(input int i, input int n);
        repeat (n) begin
            @(posedge clk);
            ext_cnt[i] <= 1'b1;
            repeat (2) @(posedge clk);
            ext_cnt[i] <= 1'b0;
            repeat (2) @(posedge clk);
        end
    endtask : ext_edges
    task automatic set_pin(input int ch, input logic v);
        @(posedge clk);
        cc_in[ch] <= v;
        repeat (5) @(posedge clk);
    endtask : set_pin
endmodule : dccu_pins_model

// ### verification/dual_capture_compare_unit_test.sv
// Self-checking bench for the dual capture/compare unit
`timescale 1ns/1ns
module dual_capture_compare_unit_test;
    logic                    clk;
    logic                    rst_b;
    dccu_pkg::dccu_axi_req_t req;
    dccu_pkg::dccu_axi_rsp_t rsp;
    logic [31:0]             cc_in;
    logic [31:0]             cc_out;
    logic [31:0]             cc_out_en_b;
    logic                    aux_ovf;
    logic [1:0]              ext_cnt;
    logic [31:0]             cc_irq;
    logic [3:0]              tmr_irq;
    int                      n_fail;
    int                      n_compared;
    int                      cyc;

    dccu_top dccu_top_inst (.clk(clk), .rst_b(rst_b), .axi_req(req),
        .axi_rsp(rsp), .cc_in(cc_in), .cc_out(cc_out),
        .cc_out_en_b(cc_out_en_b), .aux_ovf(aux_ovf), .ext_cnt(ext_cnt),
        .cc_irq(cc_irq), .tmr_irq(tmr_irq));
    dccu_pins_model dccu_pins_model_inst (.clk(clk), .cc_in(cc_in),
        .aux_ovf(aux_ovf), .ext_cnt(ext_cnt));

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task automatic tally_and_finish;
        $display("compared %0d, mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : tally_and_finish

    // Longest run is the prescaler sweep, about 33000 cycles
    always @(posedge clk) begin
        cyc++;
        if (cyc >= 60000) begin
            n_fail++;
            tally_and_finish;
        end
    end

    task automatic chk(input string nm, input logic [31:0] got, exp);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        req.awaddr  <= a;
        req.awvalid <= 1'b1;
        req.wdata   <= d;
        req.wstrb   <= 4'hF;
        req.wvalid  <= 1'b1;
        req.bready  <= 1'b1;
        do begin
            @(posedge clk);
            if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
            if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
        end while (!rsp.bvalid);
        req.bready <= 1'b0;
    endtask : wr

    task automatic rd(input logic [11:0] a, output logic [31:0] d,
                      output logic [1:0] r);
        @(posedge clk);
        req.araddr  <= a;
        req.arvalid <= 1'b1;
        req.rready  <= 1'b1;
        do begin
            @(posedge clk);
            if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
        end while (!rsp.rvalid);
        d = rsp.rdata;
        r = rsp.rresp;
        req.rready <= 1'b0;
    endtask : rd

    task automatic rc(input string nm, input logic [11:0] a,
                      input logic [31:0] e);
        logic [31:0] d;
        logic [1:0]  r;
        rd(a, d, r);
        chk(nm, d, e);
    endtask : rc

    initial begin
        logic [31:0] d;
        logic [1:0]  r;
        logic [15:0] v;
        logic [15:0] c;
        logic [15:0] c1;
        logic [11:0] a;
        int          e;
        req   = '0;
        rst_b = 1'b0;
        n_fail = 0;
        n_compared = 0;
        cyc = 0;
        v = 16'($urandom(32'h6B78CCE3));
        repeat (16) @(posedge clk);
        rst_b <= 1'b1;
        repeat (3) @(posedge clk);
        rc("ctl reset", dccu_pkg::OFS_TMR_CTL, 32'h0);
        a = 12'h140 | (12'($urandom) & 12'hEBC);
        rd(a, d, r);
        chk("unmapped resp", {30'h0, r}, {30'h0, dccu_pkg::RESP_SLVERR});
        for (int s = 0; s < 8; s++) begin
            wr(dccu_pkg::OFS_TMR_CTL, 32'h20 | s);
            rd(dccu_pkg::OFS_TMR_CNT, d, r);
            c1 = d[15:0];
            repeat (4096) @(posedge clk);
            rd(dccu_pkg::OFS_TMR_CNT, d, r);
            c = d[15:0] - c1 - 16'(4096 >> (s + 3)) + 16'h1;
            chk("prescale", {31'h0, c < 16'h3}, 32'h1);
        end
        wr(dccu_pkg::OFS_TMR_CTL, 32'h30);
        wr(dccu_pkg::OFS_TMR_CNT, 32'h0);
        dccu_pins_model_inst.ext_edges(0, 3);
        rc("ext count", dccu_pkg::OFS_TMR_CNT, 32'h3);
        wr(dccu_pkg::OFS_TMR_CTL, 32'h0);
        wr(dccu_pkg::OFS_CH_IE, 32'h1);
        for (int m = 1; m < 4; m++) begin
            wr(dccu_pkg::OFS_CH_MODE, 32'(m));
            for (int b = 1; b >= 0; b--) begin
                c = 16'($urandom);
                wr(dccu_pkg::OFS_TMR_CNT, {16'h0, c});
                wr(dccu_pkg::OFS_CH_VAL, 32'h0);
                wr(dccu_pkg::OFS_CH_IF, 32'h1);
                dccu_pins_model_inst.set_pin(0, 1'(b));
                e = int'(m == 3 || (m == 1 && b == 1) || (m == 2 && b == 0));
                rc("capture", dccu_pkg::OFS_CH_VAL,
                   (e != 0) ? {16'h0, c} : 32'h0);
                chk("capture irq", {31'h0, cc_irq[0]}, 32'(e));
            end
        end
        v = v & 16'h7FF0;
        wr(dccu_pkg::OFS_TMR_CNT + 12'h4, {16'h0, v});
        wr(dccu_pkg::OFS_TMR_RLD + 12'h4, {16'h0, v ^ 16'h8000});
        for (int ch = 5; ch < 9; ch++) begin
            wr(dccu_pkg::OFS_CH_VAL + 12'(4 * ch), {16'h0, v + 16'h1});
            wr(dccu_pkg::OFS_CH_MODE + 12'(4 * ch), 32'(ch + 15));
        end
        // Channel 3 in double mode, partner channel 11 one count later
        wr(dccu_pkg::OFS_CH_VAL + 12'h0C, {16'h0, v + 16'h1});
        wr(dccu_pkg::OFS_CH_VAL + 12'h2C, {16'h0, v + 16'h2});
        wr(dccu_pkg::OFS_CH_MODE + 12'h0C, 32'h18);
        wr(dccu_pkg::OFS_CH_MODE + 12'h60, 32'h5);
        wr(dccu_pkg::OFS_CH_IE, 32'h1E0);
        wr(dccu_pkg::OFS_TM_IE, 32'h2);
        wr(dccu_pkg::OFS_TMR_CTL + 12'h4, 32'h28);
        dccu_pins_model_inst.aux_pulse(1);
        chk("toggle pin", {31'h0, cc_out[6]}, 32'h1);
        chk("toggle drive", {31'h0, cc_out_en_b[6]}, 32'h0);
        chk("irq only", {30'h0, cc_out_en_b[5], cc_irq[5]}, 32'h3);
        chk("once irq", {31'h0, cc_irq[7]}, 32'h1);
        chk("set pin", {31'h0, cc_out[8]}, 32'h1);
        chk("double pin", {31'h0, cc_out[3]}, 32'h1);
        chk("no output", {31'h0, cc_out_en_b[24]}, 32'h1);
        wr(dccu_pkg::OFS_CH_IF, 32'h1E0);
        wr(dccu_pkg::OFS_CH_VAL + 12'h18, {16'h0, v + 16'h2});
        wr(dccu_pkg::OFS_CH_VAL + 12'h1C, {16'h0, v + 16'h2});
        dccu_pins_model_inst.aux_pulse(1);
        chk("second toggle", {31'h0, cc_out[6]}, 32'h0);
        chk("double partner", {31'h0, cc_out[3]}, 32'h0);
        chk("second irq", {31'h0, cc_irq[7]}, 32'h0);
        wr(dccu_pkg::OFS_TMR_CNT + 12'h4, 32'hFFFF);
        dccu_pins_model_inst.aux_pulse(1);
        rc("reload", dccu_pkg::OFS_TMR_CNT + 12'h4,
           {16'h0, v ^ 16'h8000});
        chk("clear pin", {31'h0, cc_out[8]}, 32'h0);
        chk("timer irq", {28'h0, tmr_irq}, 32'h2);
        wr(dccu_pkg::OFS_TM_IF, 32'h2);
        repeat (3) @(posedge clk);
        chk("timer irq clear", {28'h0, tmr_irq}, 32'h0);
        tally_and_finish;
    end
endmodule : dual_capture_compare_unit_test
